// File: hdl/pbl_pkg.sv
// pbl_pkg: shared constants for the pushbutton sequencer and status led block
// assumes a 40 MHz system clock; all times are converted to cycle counts here
package pbl_pkg;
  // ==========================================================
  // clock and time base
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / 1000;
  // ==========================================================
  // press timing, in milliseconds as printed
  localparam int unsigned SHORT_MIN_MS  = 100;
  localparam int unsigned SHORT_MAX_MS  = 2000;
  localparam int unsigned GAP_MAX_MS    = 2000;
  localparam int unsigned RESET_HOLD_MS = 3000;
  localparam int unsigned KEYGEN_MS     = 30000;
  localparam int unsigned JOIN_MAX_MS   = 30000;
  // blink timing, in milliseconds
  localparam int unsigned QUICK_MS      = 100;
  localparam int unsigned SLOW_MS       = 500;
  localparam int unsigned PKT_MS        = 50;
  // derived counts: milliseconds times MS_CYCLES, exact at 40 MHz
  localparam int unsigned SHORT_MIN_CYC = (SHORT_MIN_MS * MS_CYCLES);
  localparam int unsigned SHORT_MAX_CYC = (SHORT_MAX_MS * MS_CYCLES);
  localparam int unsigned GAP_MAX_CYC   = (GAP_MAX_MS * MS_CYCLES);
  localparam int unsigned RESET_CYC     = (RESET_HOLD_MS * MS_CYCLES);
  localparam int unsigned KEYGEN_CYC    = (KEYGEN_MS * MS_CYCLES);
  localparam int unsigned JOIN_CYC      = (JOIN_MAX_MS * MS_CYCLES);
  localparam int unsigned QUICK_CYC     = (QUICK_MS * MS_CYCLES);
  localparam int unsigned SLOW_CYC      = (SLOW_MS * MS_CYCLES);
  localparam int unsigned PKT_CYC       = (PKT_MS * MS_CYCLES);
  // ==========================================================
  // press counts that select a function
  localparam logic [2:0] NPRESS_JOIN  = 3'h1;
  localparam logic [2:0] NPRESS_TEST  = 3'h3;
  localparam logic [2:0] NPRESS_RESET = 3'h4;
  // led display patterns
  typedef enum logic [3:0] {
    PBL_PAT_OFF     = 4'h0,
    PBL_PAT_ADMIN   = 4'h1,
    PBL_PAT_NODE    = 4'h2,
    PBL_PAT_XFER    = 4'h3,
    PBL_PAT_DONE    = 4'h4,
    PBL_PAT_CANCEL  = 4'h5,
    PBL_PAT_FAIL    = 4'h6,
    PBL_PAT_HOLD    = 4'h7,
    PBL_PAT_NOKEY   = 4'h8,
    PBL_PAT_KNODE   = 4'h9,
    PBL_PAT_KADMIN  = 4'hA
  } pbl_pat_e;
endpackage

// File: hdl/pbl_sync.sv
// pbl_sync: two flop synchroniser for the pushbutton pin
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module pbl_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // pin and synchronised level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;
  // ==========================================================
  // first flop feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in; // RQ18
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pbl_blinker.sv
// pbl_blinker: plays a blink pattern on the led
// assumes the pattern is started by a one cycle start pulse; repeat 0 means forever
`timescale 1ns/1ps
`default_nettype none
module pbl_blinker
  import pbl_pkg::*;
#(
  parameter int unsigned QUICK = QUICK_CYC,
  parameter int unsigned SLOW  = SLOW_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // pattern request
  input  wire logic       start,
  input  wire logic       stop,
  input  wire logic [1:0] n_quick,   // quick blinks per group
  input  wire logic       lead_slow, // group opens with one slow blink
  input  wire logic [2:0] n_groups,  // 0 repeats forever
  // led drive and state
  output logic            led,
  output logic            busy
);
  // ==========================================================
  // one group: optional slow blink, quick blinks, then a slow gap
  logic [31:0] tmr_r;
  logic [2:0]  step_r;   // on/off half steps inside a group
  logic [2:0]  grp_r;
  logic [1:0]  nq_r;
  logic        sl_r;
  logic [2:0]  ng_r;
  logic [2:0]  last_step;
  logic        is_slow;
  logic        in_gap;
  logic [31:0] dur;
  assign last_step = {nq_r, 1'b0} + {2'h0, sl_r} + {2'h0, sl_r};
  assign in_gap    = (step_r == last_step);
  assign is_slow   = sl_r && (step_r < 3'h2);
  assign dur       = (is_slow || in_gap) ? SLOW : QUICK;
  // led lights on even half steps; the gap step stays dark
  assign led       = busy && !in_gap && !step_r[0];
  // ==========================================================
  // sequencer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy   <= 1'b0;
      tmr_r  <= 32'h0;
      step_r <= 3'h0;
      grp_r  <= 3'h0;
      nq_r   <= 2'h0;
      sl_r   <= 1'b0;
      ng_r   <= 3'h0;
    end else if (start) begin
      busy   <= 1'b1;
      tmr_r  <= 32'h0;
      step_r <= 3'h0;
      grp_r  <= 3'h0;
      nq_r   <= n_quick;
      sl_r   <= lead_slow;
      ng_r   <= n_groups;
    end else if (stop) begin
      busy <= 1'b0;
    end else if (busy) begin
      if (tmr_r + 32'h1 >= dur) begin
        tmr_r <= 32'h0;
        if (in_gap) begin
          step_r <= 3'h0;
          grp_r  <= grp_r + 3'h1;
          if (ng_r != 3'h0 && grp_r + 3'h1 == ng_r) busy <= 1'b0;
        end else begin
          step_r <= step_r + 3'h1;
        end
      end else begin
        tmr_r <= tmr_r + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/pbl_top.sv
// pbl_top: pushbutton sequence decoder and status led driver
// assumes pairing, key and radio logic on the same clock give one cycle event pulses
// Overview of operation
// RQ1: admin search shows two quick blinks, thirty seconds
// RQ2: node search shows one quick blink, thirty seconds
// RQ3: key transfer shows continuous quick blinks; code repeats three quick blinks then a slow gap
// RQ4: transfer complete shows six slow blinks
// RQ5: led follows button during pairing operations; the code lights it for a held button only while no pattern is playing
// RQ6: cancel shows two quick blinks once
// RQ7: failure shows three slow blinks
// RQ8: long hold shows slow plus two quick
// RQ9: no key test shows one-blink group thrice
// RQ10: node key test shows two-blink group thrice
// RQ11: admin key test shows three-blink group thrice
// RQ12: short press lasts 100 to 2000 ms
// RQ13: one short press starts or cancels join
// RQ14: thirty second hold requests key generation
// RQ15: four presses plus 3 s hold resets
// RQ16: three short presses request key test
// RQ17: button drives high when pressed
// RQ18: button synchronised, blink timing from parameters
// RQ19: idle led off, brief pulse on packets
`timescale 1ns/1ps
`default_nettype none
module pbl_top
  import pbl_pkg::*;
#(
  parameter int unsigned SHORT_MIN = SHORT_MIN_CYC,
  parameter int unsigned SHORT_MAX = SHORT_MAX_CYC,
  parameter int unsigned GAP_MAX   = GAP_MAX_CYC,
  parameter int unsigned RESET_HLD = RESET_CYC,
  parameter int unsigned KEYGEN    = KEYGEN_CYC,
  parameter int unsigned JOIN_MAX  = JOIN_CYC,
  parameter int unsigned QUICK     = QUICK_CYC,
  parameter int unsigned SLOW      = SLOW_CYC,
  parameter int unsigned PKT       = PKT_CYC
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // user side
  input  wire logic pushbutton_in,
  output logic      status_led_out,
  // device state from pairing and key logic
  input  wire logic is_admin,
  input  wire logic key_stored,
  // pairing events, one cycle pulses
  input  wire logic xfer_start,
  input  wire logic join_done,
  input  wire logic join_fail,
  input  wire logic pkt_activity,
  // requests, one cycle pulses
  output logic      join_req,
  output logic      cancel_req,
  output logic      keygen_req,
  output logic      factory_req,
  output logic      keytest_req,
  // status levels
  output logic      join_active
);

  // ==========================================================
  // input conditioning
  // the pin is a raw button contact; metastability is absorbed here,
  // but bounce is not filtered; every decision below reads only pb.
  // two flops cost two cycles of latency, which is nothing against
  // press times of a tenth of a second and more.

  logic pb;
  pbl_sync u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .async_in (pushbutton_in), // RQ17
    .sync_out (pb)
  );


  // ==========================================================
  // press timing
  // hi_r counts cycles of the current press and lo_r cycles of the
  // current release; both saturate so a very long idle never wraps
  // and fakes a short gap or a short press.
  // a press is judged on the cycle that the synchronised level falls,
  // using the count it had reached plus one, so a press is judged one cycle longer than pb was high.

  logic        pb_d_r;
  logic [31:0] hi_r;
  logic [31:0] lo_r;
  logic [2:0]  npress_r;
  logic        lockout_r;  // sequence spoiled: wait until pb is low for RESET_HLD cycles
  logic        hold_ack_r; // long hold recognised, waiting release
  logic        hold_fac_r; // hold is the factory reset kind
  logic        fell;
  logic        short_ok;
  logic        gap_end;
  logic        keygen_hit;
  logic        reset_hit;
  assign fell       = pb_d_r && !pb;
  assign short_ok   = (hi_r + 32'h1 >= SHORT_MIN) && (hi_r + 32'h1 <= SHORT_MAX); // RQ12
  assign gap_end    = !pb && (lo_r + 32'h1 == GAP_MAX) && (npress_r != 3'h0);
  assign keygen_hit = pb && !hold_ack_r && !lockout_r && npress_r == 3'h0
                      && (hi_r + 32'h1 == KEYGEN); // RQ14
  assign reset_hit  = pb && !hold_ack_r && !lockout_r && npress_r == NPRESS_RESET
                      && (hi_r + 32'h1 == RESET_HLD); // RQ15


  // high and low time counters
  // a press is measured on the synchronised level, not the pin
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pb_d_r <= 1'b0;
      hi_r   <= 32'h0;
      lo_r   <= 32'h0;
    end else begin
      pb_d_r <= pb;
      hi_r   <= pb ? ((hi_r == 32'hFFFF_FFFF) ? hi_r : hi_r + 32'h1) : 32'h0;
      lo_r   <= pb ? 32'h0 : ((lo_r == 32'hFFFF_FFFF) ? lo_r : lo_r + 32'h1);
    end
  end


  // press counter; a bad press spoils the whole sequence
  // a spoiled sequence is held off until the pin has been low for the
  // reset hold time, so a bouncing or fumbled entry cannot drift into
  // a different function by accident.
  // a recognised long hold ends on release and never counts as a press.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      npress_r   <= 3'h0;
      lockout_r  <= 1'b0;
      hold_ack_r <= 1'b0;
      hold_fac_r <= 1'b0;
    end else begin
      if (keygen_hit || reset_hit) begin
        hold_ack_r <= 1'b1;
        hold_fac_r <= reset_hit;
      end
      if (fell) begin
        hold_ack_r <= 1'b0;
        if (hold_ack_r) begin
          npress_r <= 3'h0;
        end else if (lockout_r || !short_ok || npress_r == 3'h7) begin
          npress_r  <= 3'h0;
          lockout_r <= 1'b1;
        end else begin
          npress_r <= npress_r + 3'h1;
        end
      end else if (gap_end) begin
        npress_r <= 3'h0;
      end
      // a long quiet spell rearms the decoder
      if (!pb && lo_r + 32'h1 >= RESET_HLD) lockout_r <= 1'b0;
    end
  end


  // ==========================================================
  // function decode, issued when the gap after the last press ends
  // waiting for the gap costs latency but is the only way to tell one
  // press from the first of three or four.
  // counts other than one and three fall through and are dropped.
  logic do_join;
  logic do_test;
  assign do_join = gap_end && !lockout_r && npress_r == NPRESS_JOIN;
  assign do_test = gap_end && !lockout_r && npress_r == NPRESS_TEST; // RQ16


  // ==========================================================
  // join session
  // the search time limit only runs while no transfer is under way;
  // once keys are moving the pairing logic decides how it ends.
  // a second single press toggles the session off as a cancel.

  logic        join_r;
  logic        xfer_r;
  logic [31:0] jt_r;
  logic        join_tmo;
  assign join_tmo    = join_r && !xfer_r && (jt_r + 32'h1 >= JOIN_MAX); // RQ1 RQ2
  assign join_active = join_r;

  // start, cancel and timeout of a join attempt
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      join_r <= 1'b0;
      xfer_r <= 1'b0;
      jt_r   <= 32'h0;
    end else begin
      jt_r <= join_r ? jt_r + 32'h1 : 32'h0;
      if (do_join) begin
        join_r <= !join_r; // RQ13
        xfer_r <= 1'b0;
      end else if (join_done || join_fail || join_tmo) begin
        join_r <= 1'b0;
        xfer_r <= 1'b0;
      end else if (xfer_start && join_r) begin
        xfer_r <= 1'b1;
      end
    end
  end


  // requests to the pairing logic
  // each request is a registered single cycle pulse, one at a time;
  // key generation and factory reset act on release of the hold.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      join_req    <= 1'b0;
      cancel_req  <= 1'b0;
      keygen_req  <= 1'b0;
      factory_req <= 1'b0;
      keytest_req <= 1'b0;
    end else begin
      join_req    <= do_join && !join_r;
      cancel_req  <= do_join && join_r; // RQ13
      keygen_req  <= fell && hold_ack_r && !hold_fac_r;
      factory_req <= fell && hold_ack_r && hold_fac_r; // factory reset acts on release
      keytest_req <= do_test;
    end
  end


  // ==========================================================
  // pattern selection: the newest event replaces the display
  // events from the pairing logic only count while a session runs,
  // so a stray done or fail pulse cannot light the led.
  // the long hold pattern wins over everything, as the user is
  // holding the button and expects to see it acknowledged.

  logic       bl_start;
  logic       bl_stop;
  logic [1:0] bl_nq;
  logic       bl_slow;
  logic [2:0] bl_ng;
  logic       bl_led;
  logic       bl_busy;
  pbl_pat_e   pat;
  always_comb begin
    pat = PBL_PAT_OFF;
    if (keygen_hit || reset_hit) pat = PBL_PAT_HOLD;
    else if (join_fail && join_r) pat = PBL_PAT_FAIL;
    else if (join_done && join_r) pat = PBL_PAT_DONE;
    else if (xfer_start && join_r) pat = PBL_PAT_XFER;
    else if (do_join && join_r) pat = PBL_PAT_CANCEL;
    else if (do_join) pat = is_admin ? PBL_PAT_ADMIN : PBL_PAT_NODE;
    else if (do_test) pat = !key_stored ? PBL_PAT_NOKEY :
                            (is_admin ? PBL_PAT_KADMIN : PBL_PAT_KNODE);
  end
  assign bl_start = (pat != PBL_PAT_OFF);
  assign bl_stop  = join_tmo || (fell && hold_ack_r);


  // pattern table: quick count, slow lead, group count
  // a group count of zero repeats until stopped or replaced;
  // the continuous transfer blink is taken as repeating three quick
  // groups so it shares the same sequencer as the other patterns.
  always_comb begin
    bl_nq   = 2'h0;
    bl_slow = 1'b0;
    bl_ng   = 3'h0;
    unique case (pat)
      PBL_PAT_OFF:    bl_ng = 3'h0;
      PBL_PAT_ADMIN:  bl_nq = 2'h2;             // RQ1
      PBL_PAT_NODE:   bl_nq = 2'h1;             // RQ2
      PBL_PAT_XFER:   bl_nq = 2'h3;             // RQ3
      PBL_PAT_DONE:   begin
        bl_slow = 1'b1;
        bl_ng   = 3'h6;                         // RQ4
      end
      PBL_PAT_CANCEL: begin
        bl_nq = 2'h2;
        bl_ng = 3'h1;                           // RQ6
      end
      PBL_PAT_FAIL:   begin
        bl_slow = 1'b1;
        bl_ng   = 3'h3;                         // RQ7
      end
      PBL_PAT_HOLD:   begin
        bl_slow = 1'b1;
        bl_nq   = 2'h2;                         // RQ8
      end
      PBL_PAT_NOKEY:  begin
        bl_nq = 2'h1;
        bl_ng = 3'h3;                           // RQ9
      end
      PBL_PAT_KNODE:  begin
        bl_nq = 2'h2;
        bl_ng = 3'h3;                           // RQ10
      end
      PBL_PAT_KADMIN: begin
        bl_nq = 2'h3;
        bl_ng = 3'h3;                           // RQ11
      end
      default:        bl_ng = 3'h0;
    endcase
  end

  pbl_blinker #(
    .QUICK (QUICK),
    .SLOW  (SLOW)
  ) u_blink (
    .clock     (clock),
    .resetn    (resetn),
    .start     (bl_start),
    .stop      (bl_stop),
    .n_quick   (bl_nq),
    .lead_slow (bl_slow),
    .n_groups  (bl_ng),
    .led       (bl_led),
    .busy      (bl_busy)
  );


  // ==========================================================
  // packet activity pulse, shown only when nothing else is
  // a new packet restarts the pulse, so steady traffic keeps the led
  // lit rather than flickering at the packet rate.

  logic [31:0] pkt_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pkt_r <= 32'h0;
    end else if (pkt_activity) begin
      pkt_r <= PKT; // RQ19
    end else if (pkt_r != 32'h0) begin
      pkt_r <= pkt_r - 32'h1;
    end
  end


  // led output register; a held button lights it unless a pattern is playing
  // the output is a flop so the pin never glitches while the pattern
  // sequencer and the priority mux settle.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_led_out <= 1'b0;
    end else if (bl_busy) begin
      status_led_out <= bl_led;
    end else if (pb) begin
      status_led_out <= 1'b1; // RQ5
    end else begin
      status_led_out <= (pkt_r != 32'h0); // RQ19
    end
  end
endmodule
`default_nettype wire

// File: tb/pbl_button_led.sv
// pbl_button_led: model of the momentary pushbutton and the status led
// assumes the bench calls its tasks; the pin is low when the button is released
`timescale 1ns/1ps
`default_nettype none
module pbl_button_led (
  // clock
  input  wire logic clock,
  // pin toward the block, led seen from it
  output logic      pb,
  input  wire logic led
);
  // ==========================================================
  // button
  // released: the external pull-down holds the pin low
  initial pb = 1'b0;
  // one press: pin high for hi cycles, then low for lo cycles
  task automatic press(input int hi, input int lo);
    @(posedge clock) pb <= 1'b1;
    repeat (hi) @(posedge clock);
    pb <= 1'b0;
    repeat (lo) @(posedge clock);
  endtask
  // ==========================================================
  // led watcher
  // counts on-runs until dark for quiet cycles; a run already lit counts once
  task automatic count_runs(input int quiet, input int lim, output int runs);
    int   dark;
    logic prev;
    runs = 0;
    dark = 0;
    prev = 1'b0;
    for (int i = 0; i < lim && dark < quiet; i++) begin
      @(posedge clock);
      if (led && !prev) runs++;
      dark = led ? 0 : dark + 1;
      prev = led;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/pbl_top_monitor.sv
// pbl_top_monitor: port level checks of the pushbutton sequencer
// assumes one clock domain; bound into pbl_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pbl_top_monitor #(
  parameter int unsigned GAP_MAX   = 80,
  parameter int unsigned RESET_HLD = 120,
  parameter int unsigned KEYGEN    = 400,
  parameter int unsigned JOIN_MAX  = 1000
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // pin and events
  input  wire logic pushbutton_in,
  input  wire logic xfer_start,
  // requests and state
  input  wire logic join_req,
  input  wire logic cancel_req,
  input  wire logic keygen_req,
  input  wire logic factory_req,
  input  wire logic keytest_req,
  input  wire logic join_active
);
  // ==========================================================
  // run lengths, saturating so a long idle never wraps to a small value
  logic [11:0] hi_r, lo_r, last_hi_r, act_r;
  logic        xfer_seen_r;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hi_r        <= '0;
      lo_r        <= '0;
      last_hi_r   <= '0;
      act_r       <= '0;
      xfer_seen_r <= 1'b0;
    end else begin
      hi_r        <= pushbutton_in ? hi_r + {11'h000, ~&hi_r} : '0;
      lo_r        <= pushbutton_in ? '0 : lo_r + {11'h000, ~&lo_r};
      last_hi_r   <= (!pushbutton_in && hi_r != '0) ? hi_r : last_hi_r;
      act_r       <= join_active ? act_r + {11'h000, ~&act_r} : '0;
      xfer_seen_r <= join_active & (xfer_seen_r | xfer_start);
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  req_onehot_a: assert property ($onehot0({join_req, cancel_req, keygen_req,
    factory_req, keytest_req})) else $error("two requests in one cycle");
  join_pulse_a: assert property (join_req |=> !join_req && join_active)
    else $error("join request not a pulse or join not active");
  cancel_end_a: assert property (cancel_req |-> $past(join_active) ##1 !join_active)
    else $error("cancel without a running join or join kept");
  gap_wait_a: assert property ((join_req || cancel_req || keytest_req) |-> lo_r >= GAP_MAX)
    else $error("sequence decoded before the gap ran out");
  keygen_hold_a: assert property (keygen_req |-> last_hi_r >= KEYGEN && !pushbutton_in)
    else $error("key generation without the full hold");
  factory_hold_a: assert property (factory_req |-> last_hi_r >= RESET_HLD)
    else $error("factory reset without the hold");
  join_bound_a: assert property (!xfer_seen_r |-> act_r <= JOIN_MAX + 4)
    else $error("join search ran past its limit");
  test_pulse_a: assert property (keytest_req |=> !keytest_req ##1 !keytest_req)
    else $error("key test request not a pulse");
endmodule
bind pbl_top pbl_top_monitor #(.GAP_MAX(GAP_MAX), .RESET_HLD(RESET_HLD), .KEYGEN(KEYGEN),
  .JOIN_MAX(JOIN_MAX)) u_mon (.clock(clock), .resetn(resetn), .pushbutton_in(pushbutton_in),
  .xfer_start(xfer_start), .join_req(join_req), .cancel_req(cancel_req),
  .keygen_req(keygen_req), .factory_req(factory_req), .keytest_req(keytest_req),
  .join_active(join_active));
`default_nettype wire

// File: tb/pbl_top_tb.sv
// pbl_top_tb: self-checking bench for the pushbutton sequencer and led
// assumes shortened counts; the button and led model sits in pbl_button_led
`timescale 1ns/1ps
`default_nettype none
module pbl_top_tb;
  localparam int GAP = 80, HLD = 120, KGN = 400, JMAX = 1000, SL = 8, PKTC = 5;
  logic       clock, resetn, pb, led, is_admin, key_stored;
  logic       join_req, cancel_req, keygen_req, factory_req, keytest_req, join_active;
  logic [3:0] ev; // pkt, fail, done, xfer
  int         error_cnt = 0, compares = 0, cyc = 0;
  wire logic [4:0] reqs = {keytest_req, factory_req, keygen_req, cancel_req, join_req};
  // ==========================================================
  // instances
  pbl_top #(.SHORT_MIN(4), .SHORT_MAX(80), .GAP_MAX(GAP), .RESET_HLD(HLD), .KEYGEN(KGN),
    .JOIN_MAX(JMAX), .QUICK(3), .SLOW(SL), .PKT(PKTC)) u_dut (.clock(clock),
    .resetn(resetn), .pushbutton_in(pb), .status_led_out(led), .is_admin(is_admin),
    .key_stored(key_stored), .xfer_start(ev[0]), .join_done(ev[1]), .join_fail(ev[2]),
    .pkt_activity(ev[3]), .join_req(join_req), .cancel_req(cancel_req),
    .keygen_req(keygen_req), .factory_req(factory_req), .keytest_req(keytest_req),
    .join_active(join_active));
  pbl_button_led u_btn (.clock(clock), .pb(pb), .led(led));
  // ==========================================================
  // clock and hang guard; the whole run needs well under the ceiling
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_int(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // one cycle event pulse toward the block
  task automatic pulse(input int idx);
    @(posedge clock) ev[idx] <= 1'b1;
    @(posedge clock) ev[idx] <= 1'b0;
  endtask
  // index 0 join, 1 cancel, 2 keygen, 3 factory, 4 key test
  task automatic wait_req(input int idx, input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge clock);
      seen = (reqs[idx] === 1'b1);
    end
  endtask
  // one short press; the led must follow the held button before any pattern
  task automatic start_join(input logic admin);
    logic seen;
    @(posedge clock) is_admin <= admin;
    fork
      u_btn.press(20, 0);
      begin
        repeat (10) @(posedge clock);
        chk_bit("led while held", 1'b1, led);
      end
    join
    wait_req(0, GAP + 20, seen);
    chk_bit("join_req", 1'b1, seen);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_packet();
    int on = 0;
    chk_bit("led idle", 1'b0, led);
    pulse(3);
    repeat (PKTC + 6) begin
      @(posedge clock);
      on += led;
    end
    chk_int("packet led cycles", PKTC, on);
  endtask
  task automatic s_admin_cancel();
    int runs;
    logic seen;
    start_join(1'b1);
    u_btn.count_runs(99, 36, runs);
    chk_int("admin search runs", 4, runs);
    u_btn.press(20, 0);
    wait_req(1, GAP + 20, seen);
    chk_bit("cancel_req", 1'b1, seen);
    u_btn.count_runs(3 * SL, 300, runs);
    chk_int("cancel runs", 2, runs);
    chk_bit("join_active after cancel", 1'b0, join_active);
  endtask
  task automatic s_node_timeout();
    int runs, n;
    start_join(1'b0);
    u_btn.count_runs(99, 36, runs);
    chk_int("node search runs", 3, runs);
    for (n = 0; n < JMAX + 50 && join_active === 1'b1; n++) @(posedge clock);
    chk_bit("join ended", 1'b0, join_active);
    chk_bit("join lasted", 1'b1, n > JMAX - 80);
    u_btn.count_runs(3 * SL, 300, runs);
  endtask
  // ev index 1 is done, 2 is fail; done shows six slow blinks, fail three
  task automatic s_finish(input int idx, input int exp);
    int runs;
    start_join(1'b1);
    pulse(0);
    u_btn.count_runs(99, 36, runs);
    chk_int("transfer runs", 5, runs);
    pulse(idx);
    u_btn.count_runs(3 * SL, 400, runs);
    chk_int("end pattern runs", exp, runs);
    chk_bit("join_active at end", 1'b0, join_active);
  endtask
  task automatic s_keytest();
    int runs;
    logic seen;
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      key_stored <= (k != 0);
      is_admin <= (k == 2);
      repeat (2) u_btn.press(20, 20);
      u_btn.press(20, 0);
      wait_req(4, GAP + 20, seen);
      chk_bit("keytest_req", 1'b1, seen);
      u_btn.count_runs(3 * SL, 600, runs);
      chk_int("key test runs", 3 * (k + 1), runs);
    end
  endtask
  task automatic s_holds();
    int runs;
    logic seen;
    fork
      u_btn.press(KGN + 60, 0);
      begin
        repeat (KGN + 10) @(posedge clock);
        u_btn.count_runs(99, 40, runs);
        chk_bit("hold pattern", 1'b1, runs >= 3);
      end
    join
    wait_req(2, 10, seen);
    chk_bit("keygen_req", 1'b1, seen);
    repeat (4) @(posedge clock);
    u_btn.count_runs(99, 30, runs);
    chk_int("led after release", 0, runs);
    repeat (4) u_btn.press(20, 20);
    u_btn.press(HLD + 40, 0);
    wait_req(3, 10, seen);
    chk_bit("factory_req", 1'b1, seen);
    u_btn.count_runs(3 * SL, 300, runs);
  endtask
  task automatic s_refused();
    logic seen;
    u_btn.press(2, 0);
    wait_req(0, GAP + 40, seen);
    chk_bit("too short press", 1'b0, seen);
    repeat (HLD + 10) @(posedge clock);
    u_btn.press(100, 0);
    wait_req(0, GAP + 40, seen);
    chk_bit("too long press", 1'b0, seen);
  endtask
  task automatic report_and_stop();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    resetn = 1'b0;
    is_admin = 1'b0;
    key_stored = 1'b0;
    ev = 4'h0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    s_packet();
    s_admin_cancel();
    s_node_timeout();
    s_finish(1, 6);
    s_finish(2, 3);
    s_keytest();
    s_holds();
    s_refused();
    report_and_stop();
  end
endmodule
`default_nettype wire
